/* src/xmrd_pkg.sv */
// Functional notes
// - latch strobe high for latch-width field [14:12] plus one cycles.
// - address held half cycle after strobe falls, plus one if bit 10 clear (here the half cycle is one whole cycle).
// - rd strobe low half cycle after latch fall, plus one per clear bit 10, 9 (here the half cycle is one whole cycle).
// - read strobe stays low for read-width field [3:0] plus one cycles.
package xmrd_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  XMRD_OFF_CTRL   = 8'h00; // bit0 start (self clear)
   localparam logic [7:0]  XMRD_OFF_PARAM  = 8'h04; // ext_mem_timing_param
   localparam logic [7:0]  XMRD_OFF_ADDR   = 8'h08; // target address
   localparam logic [7:0]  XMRD_OFF_STATUS = 8'h0C; // bit0 busy, bit1 done
   localparam logic [7:0]  XMRD_OFF_DATA   = 8'h10; // captured read data

   // ----------------------------------------------------------------
   // timing parameter fields, reset value and response codes
   // ----------------------------------------------------------------
   localparam int          XMRD_ALE_HI     = 14;
   localparam int          XMRD_ALE_LO     = 12;
   localparam int          XMRD_XHOLD_BIT  = 10;
   localparam int          XMRD_XDLY_BIT   = 9;
   localparam int          XMRD_RDW_HI     = 3;
   localparam int          XMRD_RDW_LO     = 0;
   localparam logic [15:0] XMRD_PARAM_RST  = 16'h0000;
   localparam logic [1:0]  XMRD_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  XMRD_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        region_sel;   // mem_region_select, active low
      logic        latch_strobe; // addr_latch_strobe
      logic        rd_n;         // read strobe, active low
      logic        bus_oe_n;     // low while driving address
      logic [15:0] bus_out;
   } xmrd_pins_t;

   typedef enum logic [2:0] {
      XMRD_IDLE, XMRD_SEL, XMRD_ALE, XMRD_HOLD, XMRD_RD, XMRD_REL
   } xmrd_state_t;

endpackage

/* src/xmrd_ctrl.sv */
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module xmrd_ctrl
   import xmrd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // axi4-lite slave
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // external memory pins
   output xmrd_pins_t       pins,
   input  wire logic [15:0] bus_in
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [15:0]  param;
   logic [15:0]  addr;
   logic [15:0]  rdata;
   logic         done;
   logic         start;
   logic         aw_got;
   logic         w_got;
   logic [7:0]   aw_hold;
   logic [31:0]  w_hold;
   logic [3:0]   s_hold;
   xmrd_state_t  state;
   logic [3:0]   cnt;
   logic         busy;
   logic         do_wr;
   logic [7:0]   wa;
   logic [31:0]  wd;
   logic [3:0]   ws;
   logic         wr_go;
   logic [3:0]   hold_len;

   assign busy  = (state != XMRD_IDLE);
   assign wa    = aw_got ? aw_hold : s_awaddr;
   assign wd    = w_got ? w_hold : s_wdata;
   assign ws    = w_got ? s_hold : s_wstrb;
   assign do_wr = (aw_got | s_awvalid) & (w_got | s_wvalid) &
                  ~s_bvalid & ~wr_go;
   // extra cycles before the read strobe: one per clear bit 10 and bit 9
   assign hold_len = 4'(!param[XMRD_XHOLD_BIT]) +
                     4'(!param[XMRD_XDLY_BIT]);

   // address and data channels may arrive in either order; the write
   // itself waits one edge so the response never precedes the hand-offs
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         aw_hold   <= 8'h00;
         w_hold    <= 32'h0000_0000;
         s_hold    <= 4'h0;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         wr_go     <= 1'b0;
      end else begin
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         wr_go     <= 1'b0;
         if (do_wr) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            aw_hold   <= wa;
            w_hold    <= wd;
            s_hold    <= ws;
            s_awready <= ~aw_got;
            s_wready  <= ~w_got;
            wr_go     <= 1'b1;
         end else if (!wr_go) begin
            if (s_awvalid && !aw_got && !s_bvalid && !s_awready) begin
               aw_got    <= 1'b1;
               aw_hold   <= s_awaddr;
               s_awready <= 1'b1;
            end
            if (s_wvalid && !w_got && !s_bvalid && !s_wready) begin
               w_got    <= 1'b1;
               w_hold   <= s_wdata;
               s_hold   <= s_wstrb;
               s_wready <= 1'b1;
            end
         end
      end
   end

   // write response; one outstanding write
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_bvalid <= 1'b0;
         s_bresp  <= XMRD_RESP_OKAY;
      end else if (wr_go) begin
         s_bvalid <= 1'b1;
         s_bresp  <= (aw_hold == XMRD_OFF_CTRL ||
                      aw_hold == XMRD_OFF_PARAM ||
                      aw_hold == XMRD_OFF_ADDR) ? XMRD_RESP_OKAY
                                                : XMRD_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // register writes; start ignored while a cycle runs
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         param <= XMRD_PARAM_RST;
         addr  <= 16'h0000;
         start <= 1'b0;
      end else begin
         start <= 1'b0;
         if (wr_go) begin
            if (aw_hold == XMRD_OFF_PARAM) begin
               if (s_hold[0]) param[7:0]  <= w_hold[7:0];
               if (s_hold[1]) param[15:8] <= w_hold[15:8];
            end
            if (aw_hold == XMRD_OFF_ADDR) begin
               if (s_hold[0]) addr[7:0]  <= w_hold[7:0];
               if (s_hold[1]) addr[15:8] <= w_hold[15:8];
            end
            if (aw_hold == XMRD_OFF_CTRL && s_hold[0])
               start <= w_hold[0] & ~busy;
         end
      end
   end

   // read channel
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= XMRD_RESP_OKAY;
      end else begin
         s_arready <= 1'b0;
         if (s_rvalid) begin
            if (s_rready) s_rvalid <= 1'b0;
         end else if (s_arready) begin
            // answer one edge after the hand-off; address still held here
            s_rvalid  <= 1'b1;
            s_rresp   <= XMRD_RESP_OKAY;
            unique case (s_araddr)
               XMRD_OFF_CTRL:   s_rdata <= 32'h0000_0000;
               XMRD_OFF_PARAM:  s_rdata <= {16'h0000, param};
               XMRD_OFF_ADDR:   s_rdata <= {16'h0000, addr};
               XMRD_OFF_STATUS: s_rdata <= {30'h0, done, busy};
               XMRD_OFF_DATA:   s_rdata <= {16'h0000, rdata};
               default: begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= XMRD_RESP_SLVERR;
               end
            endcase
         end else if (s_arvalid) begin
            s_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // read-cycle sequencer
   // ----------------------------------------------------------------
   // half-cycle offsets of the pin timing are rounded onto whole edges;
   // the sequencer runs on the undivided clock so counts are exact
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= XMRD_IDLE;
         cnt   <= 4'h0;
      end else begin
         unique case (state)
            XMRD_IDLE: if (start) state <= XMRD_SEL;
            XMRD_SEL: begin
               state <= XMRD_ALE;
               cnt   <= {1'b0, param[XMRD_ALE_HI:XMRD_ALE_LO]};
            end
            XMRD_ALE: begin
               if (cnt == 4'h0) begin
                  // extra cycles: one per clear bit 10 and bit 9
                  cnt   <= hold_len;
                  state <= XMRD_HOLD;
               end else cnt <= cnt - 4'h1;
            end
            XMRD_HOLD: begin
               if (cnt == 4'h0) begin
                  cnt   <= param[XMRD_RDW_HI:XMRD_RDW_LO];
                  state <= XMRD_RD;
               end else cnt <= cnt - 4'h1;
            end
            XMRD_RD: begin
               if (cnt == 4'h0) state <= XMRD_REL;
               else cnt <= cnt - 4'h1;
            end
            XMRD_REL: state <= XMRD_IDLE;
            // unused codes fall back to idle
            default:  state <= XMRD_IDLE;
         endcase
      end
   end

   // pin drive; all outputs registered, from the current state and count, param and addr
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pins <= '{region_sel: 1'b1, latch_strobe: 1'b0, rd_n: 1'b1,
                   bus_oe_n: 1'b1, bus_out: 16'h0000};
      end else begin
         // select let go one edge after the read strobe rises
         pins.region_sel   <= !(state inside {XMRD_SEL, XMRD_ALE,
                                              XMRD_HOLD, XMRD_RD});
         pins.latch_strobe <= (state == XMRD_SEL) ||
                              (state == XMRD_ALE && cnt != 4'h0);
         pins.rd_n         <= !((state == XMRD_HOLD && cnt == 4'h0) ||
                              (state == XMRD_RD && cnt != 4'h0));
         // address stays one edge past latch fall, one more if bit 10 clear
         pins.bus_oe_n     <= !((state inside {XMRD_SEL, XMRD_ALE}) ||
                              (state == XMRD_HOLD && cnt == hold_len &&
                               !param[XMRD_XHOLD_BIT]));
         pins.bus_out      <= addr;
      end
   end

   // data captured as the read strobe rises, before bus turnaround
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 16'h0000;
         done  <= 1'b0;
      end else begin
         if (state == XMRD_RD && cnt == 4'h0) begin
            rdata <= bus_in;
            done  <= 1'b1;
         end else if (start) begin
            done <= 1'b0;
         end
      end
   end

endmodule

/* bench/xmrd_ctrl_monitor.sv */
`timescale 1ns/1ns
module xmrd_ctrl_monitor
   import xmrd_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic [7:0]  s_awaddr,
   input wire logic        s_awvalid,
   input wire logic        s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic        s_wvalid,
   input wire logic        s_wready,
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire xmrd_pins_t  pins
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic [7:0]  aw_q;
   logic [15:0] w_q;
   logic [15:0] prm;
   logic [7:0]  hi_n;
   logic [7:0]  lo_n;
   logic [7:0]  gap;
   // shadow of the timing word, taken when the write completes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         aw_q <= 8'h00;
         w_q <= 16'h0000;
         prm <= XMRD_PARAM_RST;
      end else begin
         if (s_awvalid && s_awready) aw_q <= s_awaddr;
         if (s_wvalid && s_wready) w_q <= s_wdata[15:0];
         if (s_bvalid && s_bready && aw_q == XMRD_OFF_PARAM) prm <= w_q;
      end
   end
   // widths and gap counted in whole clocks
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hi_n <= 8'h00;
         lo_n <= 8'h00;
         gap <= 8'h00;
      end else begin
         hi_n <= pins.latch_strobe ? hi_n + 8'h01 : 8'h00;
         lo_n <= !pins.rd_n ? lo_n + 8'h01 : 8'h00;
         gap <= $fell(pins.latch_strobe) ? 8'h01 : gap + 8'h01;
      end
   end
   property p_latch_w;
      $fell(pins.latch_strobe) |-> hi_n == {5'h00, prm[14:12]} + 8'h01;
   endproperty
   a_latch_w: assert property (p_latch_w)
      else $error("latch strobe width wrong");
   property p_addr_hold;
      $fell(pins.latch_strobe) |->
         if (prm[10]) (!pins.bus_oe_n ##1 pins.bus_oe_n)
         else (!pins.bus_oe_n ##1 !pins.bus_oe_n ##1 pins.bus_oe_n);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address hold wrong");
   property p_rd_dly;
      $fell(pins.rd_n) |->
         gap == 8'h01 + {7'h00, !prm[10]} + {7'h00, !prm[9]};
   endproperty
   a_rd_dly: assert property (p_rd_dly)
      else $error("read strobe delay wrong");
   property p_rd_w;
      $rose(pins.rd_n) |-> lo_n == {4'h0, prm[3:0]} + 8'h01;
   endproperty
   a_rd_w: assert property (p_rd_w)
      else $error("read strobe width wrong");
   // bus must still be released and selected when data is taken
   property p_capture;
      $rose(pins.rd_n) |-> pins.bus_oe_n && !pins.region_sel;
   endproperty
   a_capture: assert property (p_capture)
      else $error("bus turned before capture");
   c_long: cover property ($fell(pins.latch_strobe) && prm[14:12] == 3'h7);
   c_fast: cover property ($fell(pins.rd_n) && gap == 8'h01);
   c_slow: cover property ($fell(pins.rd_n) && gap == 8'h03);
endmodule
bind xmrd_ctrl xmrd_ctrl_monitor u_mon (
   .core_clk(core_clk), .nrst(nrst), .s_awaddr(s_awaddr),
   .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
   .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid),
   .s_bready(s_bready), .pins(pins));

/* bench/xmrd_mem_model.sv */
`timescale 1ns/1ns
module xmrd_mem_model
   import xmrd_pkg::*;
#(
   parameter logic [15:0] KEY = 16'h5A3C
)
(
   input  wire logic       core_clk,
   input  wire xmrd_pins_t pins,
   output logic [15:0]     bus_in
);
   logic [15:0] addr_q;
   // address taken while the latch strobe is up
   always_ff @(posedge core_clk) begin
      if (pins.latch_strobe && !pins.bus_oe_n) addr_q <= pins.bus_out;
   end
   // inverse when idle so a stale capture cannot pass
   assign bus_in = (!pins.region_sel && !pins.rd_n) ? addr_q ^ KEY
                                                     : ~(addr_q ^ KEY);
endmodule

/* bench/ext_mem_read_cycle_timing_bench.sv */
`timescale 1ns/1ns
module ext_mem_read_cycle_timing_bench;
   import xmrd_pkg::*;
   localparam logic [15:0] KEY = 16'h5A3C;
   logic core_clk = 1'b0, nrst = 1'b0;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0, s_rdata, rd_v, seed;
   logic [3:0] s_wstrb = 4'hF;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic s_arvalid = 1'b0, s_rready = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp, resp;
   logic [15:0] bus_in, p;
   xmrd_pins_t pins;
   int errors = 0, total_checks = 0, cyc = 0;
   xmrd_ctrl dut (.core_clk(core_clk), .nrst(nrst), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .pins(pins), .bus_in(bus_in));
   xmrd_mem_model #(.KEY(KEY)) mem (.core_clk(core_clk), .pins(pins),
      .bus_in(bus_in));
   initial forever #5 core_clk = ~core_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (s_bvalid !== 1'b1);
      resp = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (s_rvalid !== 1'b1);
      rd_v = s_rdata;
      resp = s_rresp;
      s_rready <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // hang guard, far above a dozen read cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      seed = 32'hfa04b05f;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      rd(XMRD_OFF_PARAM);
      chk("param reset", {16'h0, XMRD_PARAM_RST}, rd_v);
      rd(8'h20);
      chk("rresp", {30'h0, XMRD_RESP_SLVERR}, {30'h0, resp});
      chk("rdata", 32'h0, rd_v);
      wr(8'h24, 32'h1);
      chk("bresp", {30'h0, XMRD_RESP_SLVERR}, {30'h0, resp});
      // corners first: all hold bits clear, then every field at maximum
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         p = (i == 0) ? 16'h0000 : (i == 1) ? 16'h7FFF : seed[15:0];
         wr(XMRD_OFF_PARAM, {16'h0, p});
         rd(XMRD_OFF_PARAM);
         chk("param", {16'h0, p}, rd_v);
         wr(XMRD_OFF_ADDR, {16'h0, seed[31:16]});
         wr(XMRD_OFF_CTRL, 32'h1);
         do rd(XMRD_OFF_STATUS); while (rd_v[1] !== 1'b1);
         // one more look, past the release edge where busy still shows
         rd(XMRD_OFF_STATUS);
         chk("status", 32'h2, rd_v);
         rd(XMRD_OFF_DATA);
         chk("data", {16'h0, seed[31:16] ^ KEY}, rd_v);
      end
      tally_and_finish();
   end
endmodule
